// [hdl/clock_select_map.svh]
/*
  Constants for the dual clock select buffer: reset values, synchroniser
  depth and switch bounds. Assumes inclusion by bare name from the package
  and design files.
*/
`ifndef CLOCK_SELECT_MAP_SVH
`define CLOCK_SELECT_MAP_SVH

// Reset values of the control state
`define GATE_RESET        1'b0
`define SYNC_RESET        1'b0

// Number of active edges the select path is resynchronised over
`define SYNC_STAGES       2

// Longest switch in the legacy select-pin preset, in slow-clock cycles
`define LEGACY_SWITCH_MAX 3

// Preset codes on the presetMode port
`define PRESET_W          3
`define PRESET_FULL       3'h0
`define PRESET_PLAIN      3'h1
`define PRESET_GATED      3'h2
`define PRESET_MUX        3'h3
`define PRESET_LEGACY     3'h4
`define PRESET_LEGACY_CE  3'h5

`endif

// [hdl/clock_select_pkg.sv]
/*
  Types for the dual clock select buffer.
  Assumes clock_select_map.svh is on the include path.
*/
`include "clock_select_map.svh"

package clock_select_pkg;

  // Last input that was validly selected
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_A,
    SEL_B
  } sel_e;

  typedef logic [`PRESET_W-1:0] preset_t;

endpackage

// [hdl/dual_clock_select_buffer.sv]
/*
  Glitch-free 2:1 clock select buffer, modelled as sampled logic on clk_sys.
  Assumes both input clocks and all controls are synchronous to clk_sys and
  much slower than it; configuration inputs are static after reset.
*/
`timescale 1ns/1ps
`include "clock_select_map.svh"

// Overview of operation
// - Input A passes only with select0 and enable0 high; B likewise with pair 1.
// - With idle 0, wait for old clock fall, hold low, start on new fall.
// - A raised bypass guard drops its input as soon as selection changes.
// - Both pairs asserted together keep the previously valid input.
// - With nothing selected the output sits at the idle level.
// - Select path is resynchronised and glitch-free; enable path is faster.
// - With selects tied high, enables switch unsynchronised but still wait for old fall.
// - Idle level sets reset output, active edge and level held while switching.
// - Startup picks choose the input used after reset; never both.
// - Guard on B lets a move from B to A finish with no B fall.
// - Plain buffer preset follows input A continuously.
// - Low-idle gate low before a rise blocks that pulse, output low.
// - Low-idle gate changes in the high phase act after the fall.
// - High-idle gate blocks on falls, holds high, completes low pulses.
// - Low-idle mux: pick drives enables; wait A low, hold until B falls.
// - High-idle mux switches on rising edges, holding the output high.
// - Legacy preset: pick drives selects; late change passes one extra pulse.
// - Legacy preset finishes the move within three slow-clock cycles.
// - Selects are taken at the active edge, enables at once.
// - With both guards high, moving select and enable to pair 1 moves to B immediately.
// - Legacy with enable: enable low drives output low after the fall.
module dual_clock_select_buffer (
  // System
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  // Input clocks
  input  wire logic                      clockInA,
  input  wire logic                      clockInB,
  // Full control set
  input  wire logic                      selectIn0,
  input  wire logic                      selectIn1,
  input  wire logic                      enableIn0,
  input  wire logic                      enableIn1,
  input  wire logic                      bypassGuardIn0,
  input  wire logic                      bypassGuardIn1,
  // Preset controls
  input  wire clock_select_pkg::preset_t presetMode,
  input  wire logic                      pickLine,
  input  wire logic                      gateEnable,
  // Configuration
  input  wire logic                      idleLevel,
  input  wire logic                      startupPickA,
  input  wire logic                      startupPickB,
  // Outputs
  output logic                           clkOut,
  output logic                           activeA,
  output logic                           activeB
);

  logic                  prevAReg;
  logic                  prevBReg;
  logic                  syncA1Reg;
  logic                  syncA2Reg;
  logic                  syncB1Reg;
  logic                  syncB2Reg;
  logic                  gateAReg;
  logic                  gateANext;
  logic                  gateBReg;
  logic                  gateBNext;
  logic                  clkOutReg;
  logic                  clkOutNext;
  clock_select_pkg::sel_e lastSelReg;
  clock_select_pkg::sel_e lastSelNext;

  // Effective controls after preset decode
  wire s0;
  wire s1;
  wire ce0;
  wire ce1;
  wire g0;
  wire g1;

  function automatic logic activeEdge(input logic prevLvl, input logic nowLvl, input logic idle);
    activeEdge = (prevLvl != idle) && (nowLvl == idle);
  endfunction

  function automatic logic presetPick(input clock_select_pkg::preset_t p, input clock_select_pkg::preset_t want);
    presetPick = (p == want);
  endfunction

  wire isFull     = presetPick(presetMode, `PRESET_FULL);
  wire isPlain    = presetPick(presetMode, `PRESET_PLAIN);
  wire isGated    = presetPick(presetMode, `PRESET_GATED);
  wire isMux      = presetPick(presetMode, `PRESET_MUX);
  wire isLegacy   = presetPick(presetMode, `PRESET_LEGACY);
  wire isLegacyCe = presetPick(presetMode, `PRESET_LEGACY_CE);

  // Unknown preset codes select nothing and idle
  assign s0  = isFull ? selectIn0 : (isPlain | isGated | isMux) ? 1'b1 : (isLegacy | isLegacyCe) & ~pickLine;
  assign s1  = isFull ? selectIn1 : isMux ? 1'b1 : (isLegacy | isLegacyCe) & pickLine;
  assign ce0 = isFull ? enableIn0 : isPlain | isLegacy | (isGated & gateEnable) | (isMux & ~pickLine)
               | (isLegacyCe & gateEnable);
  assign ce1 = isFull ? enableIn1 : isLegacy | (isMux & pickLine) | (isLegacyCe & gateEnable);
  assign g0  = isFull & bypassGuardIn0;
  assign g1  = isFull & bypassGuardIn1;

  wire edgeA  = activeEdge(prevAReg, clockInA, idleLevel);
  wire edgeB  = activeEdge(prevBReg, clockInB, idleLevel);
  wire idleA  = (clockInA == idleLevel);
  wire idleB  = (clockInB == idleLevel);

  // Guarded inputs see their select at once; others only after two active edges
  wire selA   = g0 ? s0 : syncA2Reg;
  wire selB   = g1 ? s1 : syncB2Reg;
  wire reqA   = selA & ce0;
  wire reqB   = selB & ce1;
  // Both requested: stay where we were
  wire tgtA   = reqA & (~reqB | (lastSelReg == clock_select_pkg::SEL_A));
  wire tgtB   = reqB & (~reqA | (lastSelReg == clock_select_pkg::SEL_B));

  // Unguarded inputs drop only at the idle level, so their pulse in flight completes
  wire dropA  = gateAReg & ~tgtA & (g0 | idleA);
  wire dropB  = gateBReg & ~tgtB & (g1 | idleB);
  wire freeA  = ~gateBReg | dropB;
  wire freeB  = ~gateAReg | dropA;
  // Re-enable of the same input is quick; a real switch waits for the new edge
  wire waitA  = idleA & (edgeA | lastSelReg == clock_select_pkg::SEL_A);
  wire waitB  = idleB & (edgeB | lastSelReg == clock_select_pkg::SEL_B);
  // A guard also skips the level test, so a stopped clock cannot block the move
  wire startA = ~gateAReg & tgtA & freeA & (g0 | waitA);
  wire startB = ~gateBReg & tgtB & freeB & (g1 | waitB);

  assign gateANext   = startA | (gateAReg & ~dropA);
  assign gateBNext   = startB | (gateBReg & ~dropB);
  assign lastSelNext = tgtA ? clock_select_pkg::SEL_A : tgtB ? clock_select_pkg::SEL_B : lastSelReg;
  assign clkOutNext  = gateANext ? clockInA : gateBNext ? clockInB : idleLevel;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prevAReg <= idleLevel;
      prevBReg <= idleLevel;
    end else begin
      prevAReg <= clockInA;
      prevBReg <= clockInB;
    end
  end

  // Two stages per input, stepped only by that input's active edge
  // Bounds a legacy move to about three edges of the slower clock
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      syncA1Reg <= startupPickA & ~startupPickB;
      syncA2Reg <= startupPickA & ~startupPickB;
    end else if (edgeA) begin
      syncA1Reg <= s0;
      syncA2Reg <= syncA1Reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      syncB1Reg <= startupPickB & ~startupPickA;
      syncB2Reg <= startupPickB & ~startupPickA;
    end else if (edgeB) begin
      syncB1Reg <= s1;
      syncB2Reg <= syncB1Reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gateAReg   <= startupPickA & ~startupPickB;
      gateBReg   <= startupPickB & ~startupPickA;
      lastSelReg <= startupPickA ? clock_select_pkg::SEL_A :
                    startupPickB ? clock_select_pkg::SEL_B : clock_select_pkg::SEL_NONE;
      clkOutReg  <= idleLevel;
    end else begin
      gateAReg   <= gateANext;
      gateBReg   <= gateBNext;
      lastSelReg <= lastSelNext;
      clkOutReg  <= clkOutNext;
    end
  end

  assign clkOut  = clkOutReg;
  assign activeA = gateAReg;
  assign activeB = gateBReg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_fallA;
    (clockInA != idleLevel) ##1 (clockInA == idleLevel);
  endsequence

  sequence s_fallB;
    (clockInB != idleLevel) ##1 (clockInB == idleLevel);
  endsequence

  sequence s_dropOld;
    gateBReg && !gateAReg && !g0 && !g1 ##1 !gateBReg;
  endsequence

  sequence s_bothOff;
    (!gateAReg && !gateBReg) ##1 (!gateAReg && !gateBReg);
  endsequence

  // Output path
  a_one_gate_only: assert property (!(gateAReg && gateBReg))
    else $error("both inputs gated onto the output");

  a_idle_when_none: assert property ((!gateAReg && !gateBReg) |-> clkOutReg == idleLevel)
    else $error("output not idle with no input selected");

  a_static_when_none: assert property (s_bothOff |-> $stable(clkOutReg))
    else $error("output toggled with no input selected");

  // The first cycle after reset still shows the reset level
  a_follow_a_clock: assert property ((gateAReg && !$past(sys_rst)) |-> clkOutReg == $past(clockInA))
    else $error("output does not follow input A");

  a_follow_b_clock: assert property ((gateBReg && !$past(sys_rst)) |-> clkOutReg == $past(clockInB))
    else $error("output does not follow input B");

  a_idle_after_rst: assert property ($past(sys_rst) |-> clkOutReg == idleLevel)
    else $error("output not at idle level after reset");

  // Drop and start points
  a_drop_at_idle: assert property ($fell(gateAReg) && !$past(g0) |-> $past(clockInA) == $past(idleLevel))
    else $error("input A dropped in mid pulse");

  a_drop_idle_b: assert property ($fell(gateBReg) && !$past(g1) |-> $past(clockInB) == $past(idleLevel))
    else $error("input B dropped in mid pulse");

  a_switch_held_idle: assert property (s_dropOld |-> clkOutReg == idleLevel)
    else $error("output not held idle while switching");

  a_start_on_edge: assert property (s_fallA ##0 (!gateAReg && tgtA && freeA) |=> gateAReg)
    else $error("input A not started on its active edge");

  a_start_edge_b: assert property (s_fallB ##0 (!gateBReg && tgtB && freeB) |=> gateBReg)
    else $error("input B not started on its active edge");

  a_start_idle_a: assert property ($rose(gateAReg) && !$past(g0) |-> $past(clockInA) == idleLevel)
    else $error("input A started away from its idle level");

  a_start_idle_b: assert property ($rose(gateBReg) && !$past(g1) |-> $past(clockInB) == idleLevel)
    else $error("input B started away from its idle level");

  // Guards
  a_guard_drop_now: assert property (gateBReg && g1 && !tgtB |=> !gateBReg)
    else $error("guarded input B not dropped at once");

  a_guard_drop_a: assert property (gateAReg && g0 && !tgtA |=> !gateAReg)
    else $error("guarded input A not dropped at once");

  a_guard_start_b: assert property (!gateBReg && g1 && tgtB && freeB |=> gateBReg)
    else $error("guarded input B not started at once");

  // Selection memory
  a_hold_both_req: assert property (reqA && reqB && gateAReg |=> gateAReg)
    else $error("both pairs asserted but input A lost");

  a_last_sel_a: assert property ($rose(gateAReg) |-> lastSelReg == clock_select_pkg::SEL_A)
    else $error("start of input A not remembered");

  a_last_sel_b: assert property ($rose(gateBReg) |-> lastSelReg == clock_select_pkg::SEL_B)
    else $error("start of input B not remembered");

  // Reset must not disable these two
  a_startup_pick: assert property (disable iff (1'b0)
    sys_rst && startupPickA && !startupPickB |=> gateAReg)
    else $error("startup pick of input A not applied");

  a_startup_no_a: assert property (disable iff (1'b0)
    sys_rst && !(startupPickA && !startupPickB) |=> !gateAReg)
    else $error("input A gated after reset without its pick");

  // Synchronisers
  a_sync_hold_a: assert property (!edgeA |=> $stable(syncA2Reg))
    else $error("input A select moved without an active edge");

  a_sync_hold_b: assert property (!edgeB |=> $stable(syncB2Reg))
    else $error("input B select moved without an active edge");

  a_sync_step_a: assert property (edgeA |=> syncA2Reg == $past(syncA1Reg))
    else $error("input A select did not pass its second stage");

  a_sync_step_b: assert property (edgeB |=> syncB2Reg == $past(syncB1Reg))
    else $error("input B select did not pass its second stage");

  // Preset decode
  a_no_preset_idle: assert property (!isFull && !isPlain && !isGated && !isMux && !isLegacy && !isLegacyCe
    |-> !startA && !startB)
    else $error("unknown preset started an input");

  a_plain_keeps_a: assert property (isPlain && gateAReg |=> gateAReg)
    else $error("plain preset stopped following input A");

  a_legacy_ce_tied: assert property (isLegacy |-> ce0 && ce1)
    else $error("legacy preset enables not tied high");

  a_mux_ce_pick: assert property (isMux |-> ce0 == !pickLine && ce1 == pickLine)
    else $error("mux preset enables do not follow the pick");

  a_gated_ce: assert property (isGated |-> ce0 == gateEnable && !ce1)
    else $error("gated preset enable not taken from the gate");

endmodule

// [verif/clock_source_model.sv]
/*
  Far-side model: fabric clock sources feeding both mux inputs.
  Assumes clk_sys is the fast sampling clock; edges land on its falling edge.
*/
`timescale 1ns/1ps
module clock_source_model #(
  parameter int HALF_A = 5,
  parameter int HALF_B = 7
) (
  // System
  input  wire logic clk_sys,
  // Control
  input  wire logic stopB,
  // Clocks
  output logic      clockInA,
  output logic      clockInB
);
  int cntA = 0;
  int cntB = 0;
  initial begin
    clockInA = 1'b0;
    clockInB = 1'b0;
  end
  // Stopped clock holds its level, as a dead oscillator would
  always @(negedge clk_sys) begin
    cntA <= (cntA == HALF_A - 1) ? 0 : cntA + 1;
    if (cntA == HALF_A - 1) clockInA <= ~clockInA;
    if (!stopB) begin
      cntB <= (cntB == HALF_B - 1) ? 0 : cntB + 1;
      if (cntB == HALF_B - 1) clockInB <= ~clockInB;
    end
  end
endmodule

// [verif/testbench.sv]
/*
  Self-checking bench for the dual clock select buffer.
  Assumes the design package and map header are compiled first.
*/
`timescale 1ns/1ps
`include "clock_select_map.svh"
module testbench;
  localparam int HALF_B = 7;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic s0 = 1'b0, s1 = 1'b0, e0 = 1'b0, e1 = 1'b0, g0 = 1'b0, g1 = 1'b0;
  logic pickLine = 1'b0, gateEnable = 1'b0, idleLevel = 1'b0, stopB = 1'b0;
  logic startupPickA = 1'b0, startupPickB = 1'b0;
  clock_select_pkg::preset_t presetMode = `PRESET_FULL;
  logic clockInA, clockInB, clkOut, activeA, activeB;
  int fails = 0, checks_done = 0, cycles = 0;

  always #2 clk_sys = ~clk_sys;

  clock_source_model #(.HALF_A(5), .HALF_B(HALF_B)) clock_source_model_i (.clk_sys(clk_sys), .stopB(stopB),
    .clockInA(clockInA), .clockInB(clockInB));
  dual_clock_select_buffer dual_clock_select_buffer_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clockInA(clockInA), .clockInB(clockInB), .selectIn0(s0), .selectIn1(s1), .enableIn0(e0),
    .enableIn1(e1), .bypassGuardIn0(g0), .bypassGuardIn1(g1), .presetMode(presetMode),
    .pickLine(pickLine), .gateEnable(gateEnable), .idleLevel(idleLevel), .startupPickA(startupPickA),
    .startupPickB(startupPickB), .clkOut(clkOut), .activeA(activeA), .activeB(activeB));

  task summarize;
    $display("Counts: %0d checks, %0d mismatches", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Tests need about 600 cycles; over thirty times that is a hang
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  task check(string name, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
      fails++;
    end
  endtask

  // Outputs read just after the edge that updates them
  task settle;
    @(posedge clk_sys);
    #1;
  endtask

  // Config only changes under reset; both startup picks never set together
  task automatic setup(clock_select_pkg::preset_t pm, logic il, logic sa, logic [5:0] ctl);
    @(negedge clk_sys);
    presetMode = pm;
    idleLevel = il;
    startupPickA = sa;
    {s0, e0, s1, e1, g0, g1} = ctl;
    sys_rst = 1'b1;
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
  endtask

  task automatic wait_a(logic lvl);
    int k;
    k = 0;
    while (clockInA !== lvl && k < 50) begin
      settle();
      k++;
    end
  endtask

  task automatic t_follow(clock_select_pkg::preset_t pm, logic il);
    setup(pm, il, pm == `PRESET_PLAIN, 6'h00);
    repeat (40) begin
      settle();
      if (pm == `PRESET_PLAIN) check("plain follow", clockInA, clkOut);
      else check("idle output", il, clkOut);
    end
    $display("done: follow preset %0d", pm);
  endtask

  task t_both;
    setup(`PRESET_FULL, 1'b0, 1'b1, 6'h30);
    settle();
    check("startup a", 1'b1, activeA);
    @(negedge clk_sys);
    {s1, e1} = 2'h3;
    repeat (40) begin
      settle();
      check("keep old a", 1'b1, activeA);
      check("no b", 1'b0, activeB);
    end
    $display("done: both pairs");
  endtask

  // Slow switch seen edge by edge: drop at idle, hold idle, start at idle
  task automatic t_mux(clock_select_pkg::preset_t pm, logic il);
    logic pa, pb;
    int n;
    pickLine = 1'b0;
    setup(pm, il, 1'b1, 6'h00);
    @(negedge clk_sys);
    pickLine = 1'b1;
    pa = activeA;
    pb = activeB;
    n = 0;
    while (activeB !== 1'b1 && n < 200) begin
      settle();
      n++;
      if (pa === 1'b1 && activeA === 1'b0) check("drop at idle", il, clockInA);
      if (activeA !== 1'b1 && activeB !== 1'b1) check("held idle", il, clkOut);
      if (pb === 1'b0 && activeB === 1'b1) check("start at idle", il, clockInB);
      pa = activeA;
      pb = activeB;
    end
    check("moved to b", 1'b1, activeB);
    // Two extra cycles cover the sampling latency of the model
    if (pm == `PRESET_LEGACY) check("legacy bound", 1'b1, n <= 3 * 2 * HALF_B + 2);
    $display("done: mux preset %0d idle %b", pm, il);
  endtask

  task automatic t_gate(clock_select_pkg::preset_t pm, logic il);
    logic seenLow;
    pickLine = 1'b0;
    gateEnable = 1'b1;
    setup(pm, il, 1'b1, 6'h00);
    wait_a(il);
    wait_a(~il);
    @(negedge clk_sys);
    gateEnable = 1'b0;
    seenLow = 1'b0;
    repeat (40) begin
      settle();
      if (clockInA === ~il && !seenLow) check("pulse completed", ~il, clkOut);
      else begin
        seenLow = 1'b1;
        check("gated idle", il, clkOut);
      end
    end
    $display("done: gate preset %0d idle %b", pm, il);
  endtask

  task t_guard;
    stopB = 1'b1;
    setup(`PRESET_FULL, 1'b0, 1'b1, 6'h33);
    @(negedge clk_sys);
    {s0, e0, s1, e1} = 4'h3;
    settle();
    check("guard to b", 1'b1, activeB);
    check("guard off a", 1'b0, activeA);
    stopB = 1'b0;
    $display("done: guard");
  endtask

  initial begin
    t_follow(`PRESET_PLAIN, 1'b0);
    t_follow(`PRESET_FULL, 1'b1);
    t_follow(3'h7, 1'b0);
    t_both();
    t_mux(`PRESET_MUX, 1'b0);
    t_mux(`PRESET_MUX, 1'b1);
    t_mux(`PRESET_LEGACY, 1'b0);
    t_gate(`PRESET_GATED, 1'b0);
    t_gate(`PRESET_GATED, 1'b1);
    t_gate(`PRESET_LEGACY_CE, 1'b0);
    t_guard();
    summarize();
  end
endmodule
